// ---- fps_cfg.svh ----
`ifndef FPS_CFG_SVH
`define FPS_CFG_SVH

// Register word indexes; the byte address is four times the index.
`define FPS_IDX_KEY       12'hff8
`define FPS_IDX_PAGE      12'hff9
`define FPS_IDX_SECT      12'hffa
`define FPS_IDX_STAT      12'hffb

// Reset values.
`define FPS_PAGE_RST      8'h00
`define FPS_SECT_RST      8'h00

// Key values written to the key register.
`define FPS_KEY_SECT      8'h5e
`define FPS_KEY_OPEN1     8'h73
`define FPS_KEY_OPEN2     8'h8c

// Field positions of the page choice register and of the flash address.
`define FPS_BIT_INFO      7
`define FPS_PAGE_MSB      6
`define FPS_ADDR_PAGE_LSB 9
`define FPS_SECT_MSB      11

// Information area windows.
`define FPS_INFO_BASE     16'hfe00
`define FPS_INFO_END      16'hffff
`define FPS_INFO_DATA_END 16'hfe7f

// Boot region page that the boot guard protects.
`define FPS_BOOT_PAGE     7'h00

`endif

// ---- fps_page_match.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fps_cfg.svh"

// Address decode against the selected page and the information area.
module fps_page_match
(
   // Address and selection
   input  wire logic [15:0] addr,
   input  wire logic [6:0]  page,
   // Decode results
   output logic             page_hit,
   output logic             info_win,
   output logic             info_data,
   output logic [2:0]       sector
);

   assign page_hit  = addr[15:`FPS_ADDR_PAGE_LSB] == page;
   assign info_win  = addr >= `FPS_INFO_BASE && addr <= `FPS_INFO_END;
   assign info_data = addr >= `FPS_INFO_BASE && addr <= `FPS_INFO_DATA_END;
   assign sector    = addr[`FPS_SECT_MSB:`FPS_ADDR_PAGE_LSB];

endmodule

`default_nettype wire

// ---- fps_pkg.sv ----
package fps_pkg;

   typedef enum logic [1:0]
   {
      FPS_LOCKED = 2'b00,
      FPS_KEY1   = 2'b01,
      FPS_OPEN   = 2'b11
   } fps_lock_e;

   typedef enum logic [1:0]
   {
      FPS_PROT_ALL  = 2'b00,
      FPS_PROT_BOOT = 2'b01,
      FPS_PROT_NONE = 2'b11
   } fps_prot_e;

   typedef struct packed
   {
      logic [15:0] addr;
      logic        rd;
      logic        wr;
   } fps_mem_req_s;

   typedef struct packed
   {
      logic info_sel;
      logic info_win;
      logic page_hit;
      logic write_ok;
   } fps_mem_rsp_s;

endpackage

// ---- fps_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// Three-stage pin synchroniser; a change counts once stages two and three
// agree, which also filters a single-cycle glitch.
module fps_sync
(
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Pin and clean level
   input  wire logic pin,
   output logic      level
);

   logic [2:0] stg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         stg   <= 3'h0;
         level <= 1'b0;
      end
      else
      begin
         stg <= {stg[1:0], pin};
         if (stg[2] == stg[1])
            level <= stg[2];
      end
   end

endmodule

`default_nettype wire

// ---- fps_top.sv ----
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "fps_cfg.svh"

// Overview of operation
// RULE_01: Locked plus key routes page writes to sectors.
// RULE_02: Page choice selects one of 128 512-byte pages.
// RULE_03: Erase hits addresses whose bits 15:9 match.
// RULE_04: Enable bit maps information area FE00-FFFF.
// RULE_05: Page field names erase and unlock target.
// RULE_06: Software keeps unused upper page bits zero.
// RULE_07: Two option bits give three protection levels.
// RULE_08: Options, lock, page match, sectors guard flash.
// RULE_09: Overlaid reads return information data, read-only.
// RULE_10: Software loads clock kilohertz before program/erase.
// RULE_11: Page register reads back last written value.
module fps_top
(
   // Clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // APB slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [15:0]          paddr,
   input  wire logic [31:0]          pwdata,
   input  wire logic [3:0]           pstrb,
   output logic                      pready,
   output logic [31:0]               prdata,
   output logic                      pslverr,
   // Flash option bit pins
   input  wire logic                 boot_region_write_guard,
   input  wire logic                 array_write_guard,
   // Flash access checks
   input  wire fps_pkg::fps_mem_req_s mem_req,
   output fps_pkg::fps_mem_rsp_s     mem_rsp,
   // Selection state
   output logic [7:0]                flash_page_choice
);

   // ------------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------------
   fps_pkg::fps_lock_e lock_state;
   fps_pkg::fps_lock_e next_lock_state;
   logic [7:0]         sector_guard;
   logic               sect_armed;
   logic               boot_guard_n;
   logic               array_guard_n;

   // ------------------------------------------------------------------
   // Option bit synchronisers
   // ------------------------------------------------------------------
   fps_sync u_sync_boot
   (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     (boot_region_write_guard),
      .level   (boot_guard_n)
   );

   fps_sync u_sync_array
   (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     (array_write_guard),
      .level   (array_guard_n)
   );

   // ------------------------------------------------------------------
   // Protection level
   // ------------------------------------------------------------------
   // A guard pin held low protects; the array guard dominates.
   fps_pkg::fps_prot_e prot_level;
   assign prot_level = !array_guard_n ? fps_pkg::FPS_PROT_ALL :  // RULE_07
                       !boot_guard_n  ? fps_pkg::FPS_PROT_BOOT :
                                        fps_pkg::FPS_PROT_NONE;

   // ------------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------------
   wire        apb_acc  = psel && penable && !pready;
   wire        apb_take = psel && penable && pready;
   wire        wr_take  = apb_take && pwrite && pstrb[0];
   wire        upper_ok = paddr[1:0] == 2'b00;
   wire        sel_key  = upper_ok && paddr[15:2] == {2'b00, `FPS_IDX_KEY};
   wire        sel_page = upper_ok && paddr[15:2] == {2'b00, `FPS_IDX_PAGE};
   wire        sel_sect = upper_ok && paddr[15:2] == {2'b00, `FPS_IDX_SECT};
   wire        sel_stat = upper_ok && paddr[15:2] == {2'b00, `FPS_IDX_STAT};
   wire        sel_any  = sel_key || sel_page || sel_sect || sel_stat;
   wire        locked   = lock_state != fps_pkg::FPS_OPEN;
   wire        wr_key   = wr_take && sel_key;
   wire        wr_page  = wr_take && sel_page;
   wire        to_sect  = locked && sect_armed;
   wire [7:0]  key_byte = pwdata[7:0];
   wire [7:0]  stat_byte;
   wire [31:0] rd_data;

   assign stat_byte = {4'h0, prot_level, sect_armed, !locked};
   assign rd_data   = sel_page ? {24'h0, flash_page_choice} :  // RULE_11
                      sel_sect ? {24'h0, sector_guard} :
                      sel_stat ? {24'h0, stat_byte} :
                                 32'h0;

   // ------------------------------------------------------------------
   // APB response, one wait state per access
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= apb_acc;
         pslverr <= apb_acc && !sel_any;
         if (apb_acc)
            prdata <= pwrite ? 32'h0 : rd_data;
      end
   end

   // ------------------------------------------------------------------
   // Lock sequence
   // ------------------------------------------------------------------
   // Two keys in order open the controller; any other key write, or any
   // key write while open, locks it again.
   always_comb
   begin
      next_lock_state = lock_state;
      if (wr_key)
      begin
         case (lock_state)
            fps_pkg::FPS_LOCKED:
               next_lock_state = key_byte == `FPS_KEY_OPEN1 ?
                                 fps_pkg::FPS_KEY1 : fps_pkg::FPS_LOCKED;
            fps_pkg::FPS_KEY1:
               next_lock_state = key_byte == `FPS_KEY_OPEN2 ?
                                 fps_pkg::FPS_OPEN : fps_pkg::FPS_LOCKED;
            default:
               next_lock_state = fps_pkg::FPS_LOCKED;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         lock_state <= fps_pkg::FPS_LOCKED;
      else
         lock_state <= next_lock_state;
   end

   // ------------------------------------------------------------------
   // Key arming and shared page address
   // ------------------------------------------------------------------
   wire arm_now = wr_key && locked && lock_state == fps_pkg::FPS_LOCKED
                  && key_byte == `FPS_KEY_SECT;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sect_armed <= 1'b0;
      else if (wr_key)
         sect_armed <= arm_now;
      else if (wr_page || !locked)
         sect_armed <= 1'b0;
   end

   // Sector bits only ever set; clearing needs a reset, so a stray
   // write can never lift a protection that software once asked for.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flash_page_choice <= `FPS_PAGE_RST;
         sector_guard      <= `FPS_SECT_RST;
      end
      else if (wr_page && to_sect)
         sector_guard <= sector_guard | pwdata[7:0];      // RULE_01
      else if (wr_page)
         flash_page_choice <= pwdata[7:0];                // RULE_01
   end

   // ------------------------------------------------------------------
   // Flash access checks
   // ------------------------------------------------------------------
   wire       page_hit;
   wire       info_win;
   wire       info_data;
   wire [2:0] sector;
   wire       overlay = flash_page_choice[`FPS_BIT_INFO];
   wire       boot_pg = mem_req.addr[15:`FPS_ADDR_PAGE_LSB] == `FPS_BOOT_PAGE;

   fps_page_match u_match
   (
      .addr      (mem_req.addr),
      .page      (flash_page_choice[`FPS_PAGE_MSB:0]),
      .page_hit  (page_hit),                             // RULE_03
      .info_win  (info_win),
      .info_data (info_data),
      .sector    (sector)                                // RULE_02
   );

   wire prot_ok = prot_level == fps_pkg::FPS_PROT_NONE ||  // RULE_07
                  (prot_level == fps_pkg::FPS_PROT_BOOT && !boot_pg);
   wire info_ro = overlay && info_win;                     // RULE_04
   fps_pkg::fps_mem_rsp_s next_mem_rsp;

   assign next_mem_rsp.info_sel = mem_req.rd && overlay && info_data; // RULE_09
   assign next_mem_rsp.info_win = overlay && info_win;     // RULE_04
   assign next_mem_rsp.page_hit = page_hit;                // RULE_05
   assign next_mem_rsp.write_ok = mem_req.wr && page_hit && !locked &&
                                  prot_ok && !sector_guard[sector] &&
                                  !info_ro;                // RULE_08

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mem_rsp <= '0;
      else
         mem_rsp <= next_mem_rsp;
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   apb_wait_a: assert property (apb_acc |=> pready ##1 !pready)
      else $error("APB answer not after one wait state");

   page_route_a: assert property (wr_page && !to_sect |=> // RULE_01
      flash_page_choice == $past(pwdata[7:0]))
      else $error("Page write did not reach page choice");

   sect_route_a: assert property (wr_page && to_sect |=> // RULE_01
      flash_page_choice == $past(flash_page_choice) &&
      sector_guard == ($past(sector_guard) | $past(pwdata[7:0])))
      else $error("Keyed write did not reach sector guard");

   // The flash answer is only checked from the second edge after reset
   // ends, since the first answer still carries the reset value.
   erase_hit_a: assert property (presetn |=> mem_rsp.page_hit == // RULE_03
      ($past(mem_req.addr[15:9]) == $past(flash_page_choice[6:0])))
      else $error("Page hit does not follow address bits 15:9");

   info_map_a: assert property (presetn |=> mem_rsp.info_sel == // RULE_09
      ($past(mem_req.rd) && $past(overlay) &&
       $past(mem_req.addr) >= 16'hfe00 && $past(mem_req.addr) <= 16'hfe7f))
      else $error("Information read select wrong");

   info_ro_a: assert property (mem_req.wr && overlay && info_win // RULE_04
      |=> !mem_rsp.write_ok && mem_rsp.info_win)
      else $error("Write allowed into overlaid information area");

   prot_all_a: assert property (prot_level == fps_pkg::FPS_PROT_ALL // RULE_07
      |=> !mem_rsp.write_ok)
      else $error("Write allowed under full protection");

   sect_block_a: assert property (mem_req.wr && sector_guard[sector] // RULE_08
      |=> !mem_rsp.write_ok)
      else $error("Write allowed into guarded sector");

   read_back_a: assert property (apb_acc && !pwrite && sel_page // RULE_11
      |=> prdata == {24'h0, $past(flash_page_choice)})
      else $error("Page register read back wrong");

   bad_addr_a: assert property (apb_acc && !sel_any |=> pslverr && pready)
      else $error("Unmapped access not answered with error");

   upper_zero_a: assert property (apb_acc && !pwrite |=> prdata[31:8] == 24'h0)
      else $error("Upper read data bits not zero");

   // Key effects are checked one edge after the write lands, because the
   // lock state is a register and the key byte has left the bus by then.
   sect_arm_a: assert property (wr_key && // RULE_01
      lock_state == fps_pkg::FPS_LOCKED && key_byte == `FPS_KEY_SECT
      |=> sect_armed && lock_state == fps_pkg::FPS_LOCKED)
      else $error("Sector key write did not arm the sector guard");

   lock_open_a: assert property (wr_key && // RULE_08
      lock_state == fps_pkg::FPS_KEY1 && key_byte == `FPS_KEY_OPEN2
      |=> lock_state == fps_pkg::FPS_OPEN)
      else $error("Second key did not open the controller");

   lock_gate_a: assert property (locked |=> !mem_rsp.write_ok) // RULE_08
      else $error("Write allowed while controller locked");

   page_hold_a: assert property (!wr_page |=> // RULE_11
      $stable(flash_page_choice))
      else $error("Page choice changed without a page write");

   sect_set_c: cover property (wr_page && to_sect);
   open_c: cover property (lock_state == fps_pkg::FPS_KEY1 ##[1:20]
      lock_state == fps_pkg::FPS_OPEN);
   info_read_c: cover property (mem_rsp.info_sel);
   write_ok_c: cover property (mem_rsp.write_ok);
   key_arm_c: cover property (arm_now);

endmodule

`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fps_cfg.svh"

module tb;
   logic                  pclk;
   logic                  presetn;
   logic                  psel;
   logic                  penable;
   logic                  pwrite;
   logic [15:0]           paddr;
   logic [31:0]           pwdata;
   logic [3:0]            pstrb;
   logic                  pready;
   logic [31:0]           prdata;
   logic                  pslverr;
   logic                  bguard;
   logic                  aguard;
   fps_pkg::fps_mem_req_s mem_req;
   fps_pkg::fps_mem_rsp_s mem_rsp;
   logic [7:0]            page_q;
   logic [31:0]           rd;
   logic                  err;
   int                    n_fail;
   int                    n_compared;
   int                    cycles;

   localparam logic [15:0] A_KEY  = 16'(`FPS_IDX_KEY * 4);
   localparam logic [15:0] A_PAGE = 16'(`FPS_IDX_PAGE * 4);
   localparam logic [15:0] A_SECT = 16'(`FPS_IDX_SECT * 4);
   localparam logic [15:0] A_STAT = 16'(`FPS_IDX_STAT * 4);

   fps_top i_dut
   (
      .pclk                    (pclk),
      .presetn                 (presetn),
      .psel                    (psel),
      .penable                 (penable),
      .pwrite                  (pwrite),
      .paddr                   (paddr),
      .pwdata                  (pwdata),
      .pstrb                   (pstrb),
      .pready                  (pready),
      .prdata                  (prdata),
      .pslverr                 (pslverr),
      .boot_region_write_guard (bguard),
      .array_write_guard       (aguard),
      .mem_req                 (mem_req),
      .mem_rsp                 (mem_rsp),
      .flash_page_choice       (page_q)
   );

   always #2.5 pclk = ~pclk;

   // ----------------------------------------------------------------
   // Bus and compare tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Ready is sampled at each rising edge; the request stands until it is
   // seen high there, and only the bench timeout ends a wait without it.
   task automatic apb(input logic w, input logic [15:0] a,
                      input logic [7:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00);
      chk(rd, {24'h0, exp});
   endtask

   task automatic mem(input logic [15:0] a, input logic r, input logic w,
                      input logic [3:0] exp);
      @(posedge pclk);
      mem_req <= '{addr: a, rd: r, wr: w};
      @(posedge pclk);
      #1;
      chk({28'h0, mem_rsp}, {28'h0, exp});
   endtask

   task automatic pins(input logic a, input logic b);
      @(posedge pclk);
      aguard <= a;
      bguard <= b;
      repeat (6) @(posedge pclk);
   endtask

   task automatic summarize;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_fail++;
         summarize();
      end
   end

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial
   begin
      pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
      paddr = 0; pwdata = 0; pstrb = 4'hf; bguard = 1; aguard = 1;
      mem_req = '0; n_fail = 0; n_compared = 0; cycles = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      rchk(A_PAGE, 8'h00);
      rchk(A_STAT, 8'h0c);
      for (int i = 0; i < 4; i++)
      begin
         pins(i[1], i[0]);
         rchk(A_STAT, {4'h0, i[1] ? (i[0] ? 2'b11 : 2'b01) : 2'b00,
                       2'b00});
      end
      apb(1'b1, A_PAGE, 8'h85);
      rchk(A_PAGE, 8'h85);
      chk({24'h0, page_q}, 32'h85);
      pstrb <= 4'h0;
      apb(1'b1, A_PAGE, 8'h11);
      pstrb <= 4'hf;
      rchk(A_PAGE, 8'h85);
      // These queries start no program or erase, so no kilohertz timing
      // value is owed before them.
      mem(16'hfe00, 1, 0, 4'hc);
      mem(16'hfe7f, 1, 0, 4'hc);
      mem(16'hfe80, 1, 0, 4'h4);
      mem(16'hffff, 1, 0, 4'h4);
      mem(16'hfdff, 1, 0, 4'h0);
      mem(16'h0a00, 1, 0, 4'h2);
      mem(16'h0bff, 0, 0, 4'h2);
      mem(16'h0c00, 1, 0, 4'h0);
      mem(16'h0a00, 0, 1, 4'h2);
      apb(1'b1, A_PAGE, 8'h05);
      mem(16'hfe00, 1, 0, 4'h0);
      // Armed sector key diverts the next page write to the sector guard.
      apb(1'b1, A_KEY, `FPS_KEY_SECT);
      rchk(A_STAT, 8'h0e);
      apb(1'b1, A_PAGE, 8'h02);
      rchk(A_SECT, 8'h02);
      rchk(A_PAGE, 8'h05);
      rchk(A_STAT, 8'h0c);
      apb(1'b1, A_KEY, `FPS_KEY_OPEN1);
      apb(1'b1, A_KEY, `FPS_KEY_OPEN2);
      rchk(A_STAT, 8'h0d);
      mem(16'h0a00, 0, 1, 4'h3);
      apb(1'b1, A_PAGE, 8'h01);
      mem(16'h0200, 0, 1, 4'h2);
      pins(1'b1, 1'b0);
      apb(1'b1, A_PAGE, 8'h03);
      mem(16'h0600, 0, 1, 4'h3);
      apb(1'b1, A_PAGE, 8'h00);
      mem(16'h0000, 0, 1, 4'h2);
      pins(1'b1, 1'b1);
      apb(1'b1, A_PAGE, 8'h87);
      mem(16'hfe00, 0, 1, 4'h4);
      apb(1'b1, A_KEY, 8'h00);
      rchk(A_STAT, 8'h0c);
      apb(1'b0, 16'h0000, 8'h00);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, 16'h0010, 8'h33);
      chk({31'h0, err}, 32'h1);
      rchk(A_PAGE, 8'h87);
      summarize();
   end
endmodule

`default_nettype wire
